/* rss_pkg.sv */
// Shared constants for the reset strap sampler.
// Assumes a single 20 MHz core clock and active-low asynchronous reset.
`default_nettype none
package rss_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int RESET_MIN_NS = 1000;
   localparam int RESET_MIN_CYC =
      (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ----------------------------------------
   // Widths and defaults
   // ----------------------------------------
   localparam int ADDR_W = 5;
   localparam logic [4:0] ADDR_RST = 5'h01;
   localparam logic [4:0] ISOLATE_ADDR = 5'h00;
   localparam logic AUTONEG_RST = 1'b1;
   localparam logic [1:0] CAP_RST = 2'h3;
   // Forced-mode capability encodings
   localparam logic [1:0] CAP_10_HALF = 2'h0;
   localparam logic [1:0] CAP_10_FULL = 2'h1;
   localparam logic [1:0] CAP_100_HALF = 2'h2;
   localparam logic [1:0] CAP_100_FULL = 2'h3;
   // Advertisement field positions (10H,10F,100H,100F)
   localparam int ADV_W = 4;
   localparam int ADV_10H = 0;
   localparam int ADV_10F = 1;
   localparam int ADV_100H = 2;
   localparam int ADV_100F = 3;
   localparam logic [3:0] ADV_RST = 4'hf;
endpackage
`default_nettype wire

/* rss_sampler.sv */
// Strap sampler: captures configuration pins just after hardware reset release.
// Assumes strap pins are asynchronous and pass a two-flop synchroniser.
// What this block does
// - Sample every strap pin in the clocks just after reset release, use them for modes
// - After straps_valid_out rises, pins are functional; captures other than the address stay frozen
// - Five address straps land in control register address field [4:0]
// - Any strapped address 0 through 31 is accepted
// - Strapped address zero puts the MAC interface in isolate
// - Register write of address zero never causes isolate
// - Undriven address defaults: bit 0 high, bits 4..1 low
// - Autoneg strap high advertises capability; low forces speed/duplex
// - Autoneg and capability load control and advertisement; default high
// - Reset held at least 1 us reinitialises and resamples all straps
`timescale 1ns/1ps
`default_nettype none
module rss_sampler (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic mgmt_addr_strap_bit0_in,
   input wire logic [3:0] mgmt_addr_strap_upper_in,
   input wire logic autoneg_strap_enable_in,
   input wire logic capability_strap_high_in,
   input wire logic capability_strap_low_in,
   input wire logic addr_wr_en_in,
   input wire logic [4:0] addr_wr_data_in,
   output logic [4:0] mgmt_addr_out,
   output logic isolate_out,
   output logic autoneg_enable_out,
   output logic forced_speed100_out,
   output logic forced_full_duplex_out,
   output logic [3:0] advertise_out,
   output logic straps_valid_out
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   // Two synchroniser fills, one load, then the straps other than the address stay frozen
   typedef enum logic [1:0] {
      ST_FILL_A,
      ST_FILL_B,
      ST_LOAD,
      ST_RUN
   } rss_phase_t;

   // Strap bits: {autoneg, cap high, cap low, addr[4:1], addr[0]}
   typedef struct packed {
      rss_phase_t phase;
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [4:0] addr;
      logic isolate;
      logic autoneg_strap_enable;
      logic spd100;
      logic fdx;
      logic [3:0] adv;
      logic valid;
   } rss_state_t;

   rss_state_t st_r;
   rss_state_t st_nxt;
   logic [7:0] strap_pins;
   logic [4:0] strap_addr;
   logic [1:0] cap;

   // ----------------------------------------
   // Strap pins
   // ----------------------------------------
   // Pins are asynchronous to the core clock; only sync2 feeds logic
   assign strap_pins = {autoneg_strap_enable_in, capability_strap_high_in,
                        capability_strap_low_in, mgmt_addr_strap_upper_in,
                        mgmt_addr_strap_bit0_in};
   assign strap_addr = st_r.sync2[4:0];
   assign cap = st_r.sync2[6:5];

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   // Pin drivers of the host must stay off until straps_valid_out
   // rises, so the levels taken are still the reset-time ones.
   always_comb begin
      st_nxt = st_r;
      st_nxt.sync1 = strap_pins;
      st_nxt.sync2 = st_r.sync1;
      case (st_r.phase)
         ST_FILL_A: begin
            st_nxt.phase = ST_FILL_B;
         end
         ST_FILL_B: begin
            st_nxt.phase = ST_LOAD;
         end
         ST_LOAD: begin
            // One-shot capture; later pin activity is functional traffic
            st_nxt.phase = ST_RUN;
            st_nxt.valid = 1'b1;
            st_nxt.addr = strap_addr;
            st_nxt.isolate = (strap_addr == rss_pkg::ISOLATE_ADDR);
            st_nxt.autoneg_strap_enable = st_r.sync2[7];
            // Forced pair: high bit picks 100 Mb/s, low bit full duplex
            st_nxt.spd100 = cap[1];
            st_nxt.fdx = cap[0];
            // Same pair read as an ability set when negotiating
            st_nxt.adv = 4'h0;
            case (cap)
               rss_pkg::CAP_10_HALF: begin
                  st_nxt.adv[rss_pkg::ADV_10H] = 1'b1;
                  st_nxt.adv[rss_pkg::ADV_10F] = 1'b1;
               end
               rss_pkg::CAP_10_FULL: begin
                  st_nxt.adv[rss_pkg::ADV_100H] = 1'b1;
                  st_nxt.adv[rss_pkg::ADV_100F] = 1'b1;
               end
               rss_pkg::CAP_100_HALF: begin
                  st_nxt.adv[rss_pkg::ADV_10H] = 1'b1;
                  st_nxt.adv[rss_pkg::ADV_100H] = 1'b1;
               end
               default: begin
                  st_nxt.adv = rss_pkg::ADV_RST;
               end
            endcase
         end
         ST_RUN: begin
            // Writes before the load completes are dropped
            if (addr_wr_en_in) begin
               // Moves the address only; isolate stays as strapped
               st_nxt.addr = addr_wr_data_in;
            end
         end
         default: begin
            st_nxt.phase = ST_FILL_A;
         end
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         // Pad pull levels stand until a fresh capture
         st_r.phase <= ST_FILL_A;
         st_r.sync1 <= 8'h00;
         st_r.sync2 <= 8'h00;
         st_r.addr <= rss_pkg::ADDR_RST;
         st_r.isolate <= 1'b0;
         st_r.autoneg_strap_enable <= rss_pkg::AUTONEG_RST;
         st_r.spd100 <= rss_pkg::CAP_RST[1];
         st_r.fdx <= rss_pkg::CAP_RST[0];
         st_r.adv <= rss_pkg::ADV_RST;
         st_r.valid <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign mgmt_addr_out = st_r.addr;
   assign isolate_out = st_r.isolate;
   assign autoneg_enable_out = st_r.autoneg_strap_enable;
   assign forced_speed100_out = st_r.spd100;
   assign forced_full_duplex_out = st_r.fdx;
   assign advertise_out = st_r.adv;
   assign straps_valid_out = st_r.valid;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_FILL_TO_LOAD: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (st_r.phase == ST_FILL_B) |=> (st_r.phase == ST_LOAD)
   ) else $error("strap fill did not reach the load step");

   AST_LOAD_ONCE: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (st_r.phase == ST_LOAD) |=> (st_r.phase == ST_RUN) && straps_valid_out
   ) else $error("strap load did not finish in one cycle");

   AST_ADDR_CAPTURE: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (st_r.phase == ST_LOAD) |=> (mgmt_addr_out == $past(strap_addr))
   ) else $error("strapped address not captured");

   AST_ISOLATE_STRAP: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (st_r.phase == ST_LOAD) |=>
         (isolate_out == ($past(strap_addr) == 5'h00))
   ) else $error("isolate does not follow the strapped address");

   AST_ISOLATE_FROZEN: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      straps_valid_out |=> $stable(isolate_out)
   ) else $error("isolate changed after capture");

   AST_VALID_HOLD: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      straps_valid_out |=> straps_valid_out
   ) else $error("strap valid dropped without reset");

   AST_STRAPS_FROZEN: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      straps_valid_out |=> $stable(autoneg_enable_out) &&
         $stable(advertise_out) && $stable(forced_speed100_out) &&
         $stable(forced_full_duplex_out)
   ) else $error("mode straps changed after capture");

   AST_ADDR_FROZEN: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (straps_valid_out && !addr_wr_en_in) |=> $stable(mgmt_addr_out)
   ) else $error("address changed without a write");

   AST_ADDR_WRITE: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (straps_valid_out && addr_wr_en_in) |=>
         (mgmt_addr_out == $past(addr_wr_data_in))
   ) else $error("address write not applied");

   AST_AUTONEG_LOAD: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (st_r.phase == ST_LOAD) |=>
         (autoneg_enable_out == $past(st_r.sync2[7]))
   ) else $error("autoneg strap not captured");

   AST_FORCED_DECODE: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (st_r.phase == ST_LOAD) |=>
         ({forced_speed100_out, forced_full_duplex_out} == $past(cap))
   ) else $error("forced speed or duplex decode wrong");

   AST_ADV_TEN_PAIR: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (st_r.phase == ST_LOAD && cap == 2'h0) |=> (advertise_out == 4'h3)
   ) else $error("advertisement wrong for pair 00");

   AST_ADV_HUNDRED_PAIR: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (st_r.phase == ST_LOAD && cap == 2'h1) |=> (advertise_out == 4'hc)
   ) else $error("advertisement wrong for pair 01");

   AST_ADV_HALF_PAIR: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (st_r.phase == ST_LOAD && cap == 2'h2) |=> (advertise_out == 4'h5)
   ) else $error("advertisement wrong for pair 10");

   AST_ADV_ALL: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (st_r.phase == ST_LOAD && cap == 2'h3) |=> (advertise_out == 4'hf)
   ) else $error("advertisement wrong for pair 11");
endmodule
`default_nettype wire

/* rss_strap_board.sv */
// Board strap resistors for the strap sampler bench.
// Assumes one bit per strap pin: {autoneg, cap high, cap low, addr[4:0]}.
`timescale 1ns/1ps
`default_nettype none
module rss_strap_board (
   input wire logic fit_in,
   input wire logic [7:0] val_in,
   output logic [7:0] pin_out
);
   // Unfitted pins rest at the internal pull levels
   assign pin_out = fit_in ? val_in : 8'he1;
endmodule
`default_nettype wire

/* rss_sampler_bench.sv */
// Self-checking bench for the reset strap sampler.
// Assumes outputs settle once straps_valid_out rises after reset release.
`timescale 1ns/1ps
`default_nettype none
module rss_sampler_bench;
logic clk = 0, rst_n = 0, fit = 0, wr = 0;
logic [7:0] v = 8'h00, e;
logic [7:0] p;
logic [4:0] a;
logic [3:0] adv;
logic iso, an, s100, fd, ok;
logic [3:0] advt [4] = '{4'h3, 4'hc, 4'h5, 4'hf};
int failures = 0, checks_done = 0;
always #25 clk = ~clk;
rss_strap_board u_rss_strap_board (.fit_in(fit), .val_in(v), .pin_out(p));
rss_sampler u_rss_sampler (.core_clk_in(clk), .rst_n_in(rst_n),
   .mgmt_addr_strap_bit0_in(p[0]), .mgmt_addr_strap_upper_in(p[4:1]),
   .autoneg_strap_enable_in(p[7]), .capability_strap_high_in(p[6]),
   .capability_strap_low_in(p[5]), .addr_wr_en_in(wr),
   .addr_wr_data_in(5'h00), .mgmt_addr_out(a), .isolate_out(iso),
   .autoneg_enable_out(an), .forced_speed100_out(s100),
   .forced_full_duplex_out(fd), .advertise_out(adv),
   .straps_valid_out(ok));
task chk(string n, logic [4:0] s, logic [4:0] x);
   checks_done++;
   if (s !== x) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, x, s);
   end
endtask
task final_report;
   $display("checks %0d failures %0d", checks_done, failures);
   if (failures == 0 && checks_done > 0) $display("Test passed");
   else $display("Test failed");
   $finish;
endtask
// Fitted pins flip after capture: outputs must keep the reset-time levels
task boot(logic f, logic [7:0] val);
   int i;
   @(posedge clk);
   fit <= f;
   v <= val;
   rst_n <= 0;
   e = f ? val : 8'he1;
   repeat (rss_pkg::RESET_MIN_CYC) @(posedge clk);
   rst_n <= 1;
   for (i = 0; i < 60 && ok !== 1'b1; i++) @(negedge clk);
   if (ok !== 1'b1) begin
      failures++;
      final_report();
   end else begin
      @(posedge clk);
      v <= ~val;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("addr", a, e[4:0]);
      chk("isolate", iso, e[4:0] == 5'h00);
      chk("autoneg", an, e[7]);
   end
endtask
initial begin
   boot(0, 8'h00);
   chk("adv", adv, 4'hf);
   chk("speed", s100, 1'b1);
   chk("duplex", fd, 1'b1);
   $display("default strap test done");
   foreach (advt[k]) begin
      boot(1, {3'h7, 5'h1f - 5'(k * 10)});
      boot(1, {1'b0, 2'(k), 5'h02});
      chk("speed", s100, 5'(k >> 1));
      chk("duplex", fd, 5'(k & 1));
      boot(1, {1'b1, 2'(k), 5'h02});
      chk("adv", adv, advt[k]);
   end
   $display("address and capability test done");
   boot(1, 8'he0);
   boot(1, 8'he4);
   $display("isolate strap test done");
   @(posedge clk);
   wr <= 1;
   @(posedge clk);
   wr <= 0;
   repeat (3) @(posedge clk);
   @(negedge clk);
   chk("wr isolate", iso, 1'b0);
   chk("wr addr", a, 5'h00);
   $display("address write test done");
   final_report();
end
endmodule
`default_nettype wire
